// *** cfsa_core.sv ***
/*
 cpu slice: stack sequencing, operand addresses,
 status flags and branch conditions.
 assumes the register file and memories answer a read in the same cycle
 as the read strobe, and that the decoder drives one request at a time.
*/
// Behaviour
// - push pre-decrements the stack address, pop post-increments it.
// - call pushes the program counter, return pops it back.
// - interrupt entry pushes counter and flags; interrupt return restores both.
// - internal stack addresses by low pointer byte only; high byte untouched.
// - register mode yields the selected register or pair contents as operand.
// - pointer mode uses register contents as the operand address.
// - program and data memory pointers come from a register pair.
// - index mode adds a working register to the given register address.
// - absolute mode gives the full inline address from the instruction for far branch and call.
// - offset mode adds a signed byte to the next instruction address.
// - inline mode takes the operand from the instruction in program space.
// - six hardware flags; carry, zero, sign, overflow are branch testable.
// - two user bits change only by explicit writes or interrupt return, never in conditions.
// - carry follows carry out of or borrow into bit seven.
// - rotates and shifts leave the last bit out in carry; set/clear/invert.
// - zero flag set when the result is zero.
// - sign flag takes the result's top bit.
// - overflow on signed range excess; logic operations clear it.
// - decimal-adjust flag set by subtraction, cleared by addition.
// - half-carry follows carry out of or borrow into the low nibble.
// - upper opcode nibble selects one of sixteen flag conditions.
// - working register number joins the group base's upper nibble.
// - port configuration bit chooses internal or external stack.
`include "cfsa_map.svh"
`timescale 1ns/1ps
`default_nettype none

module cfsa_core
	import cfsa_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// control register port
	input wire logic regWrEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// alu request
	input wire logic aluGo,
	input wire cfsa_alu_op_t aluOp,
	input wire logic [7:0] aluA,
	input wire logic [7:0] aluB,
	output logic [7:0] aluResult,
	output logic aluDone,
	// branch condition
	input wire logic [7:0] opcodeByte,
	output logic condTrue,
	output cfsa_flags_t flagsView,
	// address generation
	input wire logic agGo,
	input wire cfsa_mode_t agMode,
	input wire cfsa_space_t agSpace,
	input wire logic agWide,
	input wire logic [7:0] agRegField,
	input wire logic [3:0] agIdxField,
	input wire logic [7:0] agRegVal,
	input wire logic [15:0] agPairVal,
	input wire logic [7:0] agIdxVal,
	input wire logic [15:0] agInline,
	input wire logic [15:0] agNextPc,
	output logic [7:0] agRegAddr,
	output logic [15:0] agAddr,
	output logic [15:0] agOperand,
	output cfsa_space_t agSpaceOut,
	output logic agAddrValid,
	output logic agOperandValid,
	output logic agDone,
	// stack request
	input wire logic stkGo,
	input wire cfsa_stk_op_t stkOp,
	input wire logic [7:0] stkData,
	input wire logic [15:0] pcIn,
	output logic stkBusy,
	output logic stkDone,
	output logic [7:0] popData,
	output logic [15:0] pcOut,
	output logic pcLoad,
	// stack memory access
	input wire logic [7:0] memRdData,
	output logic [15:0] memAddr,
	output logic memInternal,
	output logic memWr,
	output logic memRd,
	output logic [7:0] memWrData
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_PUSH_D, ST_PUSH_PL, ST_PUSH_PH, ST_PUSH_F,
		ST_POP_D, ST_POP_F, ST_POP_PH, ST_POP_PL
	} cfsa_stk_st_t;

	cfsa_flags_t flags_r;
	cfsa_flags_t aluFlags;
	logic [7:0] groupBase_r;
	logic [7:0] spHi_r;
	logic [7:0] spLo_r;
	logic [7:0] portCfg_r;
	logic [7:0] aluRes;
	logic condW;
	cfsa_stk_st_t st_r;
	cfsa_stk_st_t st_nxt;
	cfsa_stk_op_t op_r;
	cfsa_stk_st_t cap_r;
	logic stkInt_r;
	logic [7:0] data_r;
	logic [15:0] pcSave_r;
	logic [15:0] sp;
	logic [15:0] sp_nxt;
	logic [15:0] acc_nxt;
	logic isPush;
	logic useInt;

	// =============================================
	// helpers
	function automatic logic [7:0] wrkAddr(input logic [7:0] field, input logic [7:0] grp);
		if (field[7:4] == `CFSA_WRK_PREFIX)
			wrkAddr = {grp[7:4], field[3:0]};
		else
			wrkAddr = field;
	endfunction

	cfsa_flag_unit u_flags (
		.op(aluOp),
		.opA(aluA),
		.opB(aluB),
		.flagsIn(flags_r),
		.condSel(opcodeByte[7:4]),
		.result(aluRes),
		.flagsOut(aluFlags),
		.condTrue(condW)
	);

	// =============================================
	// status flags by priority
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			flags_r <= `CFSA_RST_FLAGS;
		else if (cap_r == ST_POP_F)
			flags_r <= memRdData;
		else if (aluGo)
			flags_r <= aluFlags;
		else if (regWrEn && regAddr == `CFSA_OFS_FLAGS)
			flags_r <= regWrData;
	end

	// =============================================
	// alu and condition outputs
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			aluResult <= 8'h00;
			aluDone <= 1'b0;
			condTrue <= 1'b0;
			flagsView <= `CFSA_RST_FLAGS;
		end
		else
		begin
			aluDone <= aluGo;
			if (aluGo)
				aluResult <= aluRes;
			condTrue <= condW;
			flagsView <= flags_r;
		end
	end

	// =============================================
	// group base and port configuration
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			groupBase_r <= `CFSA_RST_GROUP;
			portCfg_r <= `CFSA_RST_PCFG;
		end
		else if (regWrEn)
		begin
			if (regAddr == `CFSA_OFS_GROUP)
				groupBase_r <= regWrData;
			if (regAddr == `CFSA_OFS_PCFG)
				portCfg_r <= regWrData;
		end
	end

	// =============================================
	// register read port
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			regRdData <= 8'h00;
		else
		begin
			case (regAddr)
				`CFSA_OFS_FLAGS: regRdData <= flags_r;
				`CFSA_OFS_GROUP: regRdData <= groupBase_r & `CFSA_GROUP_RD_MASK;
				`CFSA_OFS_SP_HI: regRdData <= spHi_r;
				`CFSA_OFS_SP_LO: regRdData <= spLo_r;
				`CFSA_OFS_PCFG: regRdData <= portCfg_r;
				default: regRdData <= 8'h00;
			endcase
		end
	end

	// =============================================
	// operand address generation
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			agRegAddr <= 8'h00;
			agAddr <= 16'h0000;
			agOperand <= 16'h0000;
			agSpaceOut <= SPACE_REGFILE;
			agAddrValid <= 1'b0;
			agOperandValid <= 1'b0;
			agDone <= 1'b0;
		end
		else
		begin
			agDone <= agGo;
			if (agGo)
			begin
				agRegAddr <= wrkAddr(agRegField, groupBase_r);
				agAddrValid <= 1'b1;
				agOperandValid <= 1'b0;
				agSpaceOut <= SPACE_PROGRAM;
				case (agMode)
					MODE_REG:
					begin
						agOperand <= agWide ? agPairVal : {8'h00, agRegVal};
						agOperandValid <= 1'b1;
						agAddrValid <= 1'b0;
						agSpaceOut <= SPACE_REGFILE;
					end
					MODE_POINTER:
					begin
						agSpaceOut <= agSpace;
						if (agSpace == SPACE_REGFILE)
							agAddr <= {8'h00, agRegVal};
						else
							agAddr <= agPairVal;
					end
					MODE_INDEX:
					begin
						agRegAddr <= wrkAddr({`CFSA_WRK_PREFIX, agIdxField}, groupBase_r);
						agAddr <= {8'h00, agRegField + agIdxVal};
						agSpaceOut <= SPACE_REGFILE;
					end
					MODE_ABSOLUTE: agAddr <= agInline;
					MODE_PCOFFSET: agAddr <= agNextPc + {{8{agInline[7]}}, agInline[7:0]};
					MODE_INLINE:
					begin
						agOperand <= {8'h00, agInline[7:0]};
						agOperandValid <= 1'b1;
						agAddrValid <= 1'b0;
					end
					default: agAddrValid <= 1'b0;
				endcase
			end
		end
	end

	// =============================================
	// stack sequencing
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE:
			begin
				if (stkGo)
				begin
					case (stkOp)
						STK_PUSH: st_nxt = ST_PUSH_D;
						STK_POP: st_nxt = ST_POP_D;
						STK_CALL, STK_INT: st_nxt = ST_PUSH_PL;
						STK_RET: st_nxt = ST_POP_PH;
						default: st_nxt = ST_POP_F;
					endcase
				end
			end
			ST_PUSH_PL: st_nxt = ST_PUSH_PH;
			ST_PUSH_PH: st_nxt = (op_r == STK_INT) ? ST_PUSH_F : ST_IDLE;
			ST_POP_F: st_nxt = ST_POP_PH;
			ST_POP_PH: st_nxt = ST_POP_PL;
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_comb
	begin
		useInt = (st_r == ST_IDLE) ? portCfg_r[`CFSA_PCFG_STK_BIT] : stkInt_r;
		sp = useInt ? {8'h00, spLo_r} : {spHi_r, spLo_r};
		isPush = (st_nxt == ST_PUSH_D) || (st_nxt == ST_PUSH_PL) ||
			(st_nxt == ST_PUSH_PH) || (st_nxt == ST_PUSH_F);
		sp_nxt = isPush ? sp - 16'h0001 : sp + 16'h0001;
		acc_nxt = isPush ? sp_nxt : sp;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			st_r <= ST_IDLE;
			op_r <= STK_PUSH;
			stkInt_r <= 1'b0;
			data_r <= 8'h00;
			pcSave_r <= 16'h0000;
		end
		else
		begin
			st_r <= st_nxt;
			if (st_r == ST_IDLE && stkGo)
			begin
				op_r <= stkOp;
				stkInt_r <= portCfg_r[`CFSA_PCFG_STK_BIT];
				data_r <= stkData;
				pcSave_r <= pcIn;
			end
		end
	end

	// stack pointer, hardware first
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			spHi_r <= `CFSA_RST_SP;
			spLo_r <= `CFSA_RST_SP;
		end
		else if (st_nxt != ST_IDLE)
		begin
			spLo_r <= sp_nxt[7:0];
			if (!useInt)
				spHi_r <= sp_nxt[15:8];
		end
		else if (regWrEn)
		begin
			if (regAddr == `CFSA_OFS_SP_HI)
				spHi_r <= regWrData;
			if (regAddr == `CFSA_OFS_SP_LO)
				spLo_r <= regWrData;
		end
	end

	// memory strobes
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			memAddr <= 16'h0000;
			memInternal <= 1'b0;
			memWr <= 1'b0;
			memRd <= 1'b0;
			memWrData <= 8'h00;
			cap_r <= ST_IDLE;
		end
		else
		begin
			memWr <= isPush;
			memRd <= (st_nxt != ST_IDLE) && !isPush;
			cap_r <= isPush ? ST_IDLE : st_nxt;
			if (st_nxt != ST_IDLE)
			begin
				memAddr <= acc_nxt;
				memInternal <= useInt;
			end
			case (st_nxt)
				ST_PUSH_D: memWrData <= (st_r == ST_IDLE) ? stkData : data_r;
				ST_PUSH_PL: memWrData <= (st_r == ST_IDLE) ? pcIn[7:0] : pcSave_r[7:0];
				ST_PUSH_PH: memWrData <= pcSave_r[15:8];
				ST_PUSH_F: memWrData <= flags_r;
				default: memWrData <= memWrData;
			endcase
		end
	end

	// read capture, busy and completion
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			popData <= 8'h00;
			pcOut <= 16'h0000;
			pcLoad <= 1'b0;
			stkBusy <= 1'b0;
			stkDone <= 1'b0;
		end
		else
		begin
			if (cap_r == ST_POP_D)
				popData <= memRdData;
			if (cap_r == ST_POP_PH)
				pcOut[15:8] <= memRdData;
			if (cap_r == ST_POP_PL)
				pcOut[7:0] <= memRdData;
			stkBusy <= st_nxt != ST_IDLE;
			stkDone <= (st_r != ST_IDLE) && (st_nxt == ST_IDLE);
			pcLoad <= (st_r == ST_POP_PL);
		end
	end

endmodule

`default_nettype wire

// *** cfsa_core_chk.sv ***
/*
 checks on the core's ports.
 assumes a bind, reset active high.
*/
`timescale 1ns/1ps
`default_nettype none

module cfsa_core_chk
	import cfsa_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// alu
	input wire logic aluGo,
	input wire cfsa_alu_op_t aluOp,
	input wire logic [7:0] aluA,
	input wire logic [7:0] aluB,
	input wire logic [7:0] aluResult,
	input wire cfsa_flags_t flagsView,
	// address generation
	input wire logic agGo,
	input wire cfsa_mode_t agMode,
	input wire logic [15:0] agInline,
	input wire logic [15:0] agNextPc,
	input wire logic [15:0] agAddr,
	input wire cfsa_space_t agSpaceOut,
	// stack
	input wire logic stkGo,
	input wire cfsa_stk_op_t stkOp,
	input wire logic [7:0] stkData,
	input wire logic [15:0] pcIn,
	input wire logic stkBusy,
	input wire logic stkDone,
	input wire logic pcLoad,
	input wire logic memWr,
	input wire logic memRd,
	input wire logic [7:0] memWrData
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire stkTake = stkGo && !stkBusy;

	// =============================================
	// flags
	carry_add_a: assert property (aluGo && aluOp == ALU_ADD |-> ##2 flagsView.c ==
		({1'b0, $past(aluA, 2)} + {1'b0, $past(aluB, 2)} > 9'h0FF)) else $error("carry wrong");
	half_carry_a: assert property (aluGo && aluOp == ALU_ADD |-> ##2 flagsView.h ==
		({1'b0, $past(aluA[3:0], 2)} + {1'b0, $past(aluB[3:0], 2)} > 5'h0F))
		else $error("half carry wrong");
	zero_sign_a: assert property (aluGo && aluOp inside {ALU_ADD, ALU_SUB, ALU_AND} |-> ##2
		flagsView.z == ($past(aluResult) == 8'h00) && flagsView.s == $past(aluResult[7]))
		else $error("zero or sign wrong");
	logic_ovf_a: assert property (aluGo && aluOp inside {ALU_AND, ALU_OR, ALU_XOR} |-> ##2
		!flagsView.v) else $error("overflow not cleared");
	dec_flag_a: assert property (aluGo && aluOp inside {ALU_SUB, ALU_SBC} |-> ##2
		flagsView.d) else $error("decimal flag not set");
	user_bits_a: assert property (aluGo |-> ##2 flagsView[1:0] == $past(flagsView[1:0]))
		else $error("user bits changed");

	// =============================================
	// stack
	push_order_a: assert property (stkTake && stkOp == STK_PUSH |=>
		memWr && memWrData == $past(stkData) ##1 stkDone) else $error("push order wrong");
	call_save_a: assert property (stkTake && stkOp == STK_CALL |=> memWr &&
		memWrData == $past(pcIn[7:0]) ##1 memWr && memWrData == $past(pcIn[15:8], 2) ##1 stkDone)
		else $error("call save wrong");
	int_ret_a: assert property (stkTake && stkOp == STK_INTRET |=> memRd[*3] ##1
		pcLoad && stkDone) else $error("interrupt return wrong");

	// =============================================
	// address generation
	pc_offset_a: assert property (agGo && agMode == MODE_PCOFFSET |=> agAddr ==
		$past(agNextPc) + {{8{$past(agInline[7])}}, $past(agInline[7:0])})
		else $error("offset target wrong");
	abs_target_a: assert property (agGo && agMode == MODE_ABSOLUTE |=>
		agAddr == $past(agInline) && agSpaceOut == SPACE_PROGRAM) else $error("absolute wrong");
endmodule

`default_nettype wire

// *** cfsa_flag_unit.sv ***
/*
 alu result, status flags and branch condition.
 assumes combinational use by the core.
*/
`timescale 1ns/1ps
`default_nettype none

module cfsa_flag_unit
	import cfsa_pkg::*;
(
	// operation
	input wire cfsa_alu_op_t op,
	input wire logic [7:0] opA,
	input wire logic [7:0] opB,
	input wire cfsa_flags_t flagsIn,
	input wire logic [3:0] condSel,
	// results
	output logic [7:0] result,
	output cfsa_flags_t flagsOut,
	output logic condTrue
);

	logic [8:0] wide;
	logic [4:0] half;
	logic cin;
	logic setZs;
	logic base;

	// =============================================
	// result and flags
	always_comb
	begin
		wide = 9'h000;
		half = 5'h00;
		result = opA;
		flagsOut = flagsIn;
		setZs = 1'b1;
		cin = 1'b0;
		case (op)
			ALU_ADD, ALU_ADC:
			begin
				cin = (op == ALU_ADC) ? flagsIn.c : 1'b0;
				wide = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
				half = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
				result = wide[7:0];
				flagsOut.c = wide[8];
				flagsOut.h = half[4];
				flagsOut.d = 1'b0;
				flagsOut.v = (opA[7] == opB[7]) && (result[7] != opA[7]);
			end
			ALU_SUB, ALU_SBC, ALU_CP:
			begin
				cin = (op == ALU_SBC) ? flagsIn.c : 1'b0;
				wide = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
				half = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, cin};
				result = wide[7:0];
				flagsOut.c = wide[8];
				flagsOut.v = (opA[7] != opB[7]) && (result[7] != opA[7]);
				if (op != ALU_CP)
				begin
					flagsOut.h = half[4];
					flagsOut.d = 1'b1;
				end
			end
			ALU_AND, ALU_OR, ALU_XOR, ALU_TM, ALU_COM:
			begin
				case (op)
					ALU_OR: result = opA | opB;
					ALU_XOR: result = opA ^ opB;
					ALU_COM: result = ~opA;
					default: result = opA & opB;
				endcase
				flagsOut.v = 1'b0;
			end
			ALU_INC, ALU_DEC:
			begin
				result = (op == ALU_INC) ? opA + 8'h01 : opA - 8'h01;
				flagsOut.v = (result[7] != opA[7]) && (result[7] == (op == ALU_INC));
			end
			ALU_ROL, ALU_ROLC, ALU_ROR, ALU_RORC, ALU_SRA:
			begin
				case (op)
					ALU_ROL: result = {opA[6:0], opA[7]};
					ALU_ROLC: result = {opA[6:0], flagsIn.c};
					ALU_ROR: result = {opA[0], opA[7:1]};
					ALU_RORC: result = {flagsIn.c, opA[7:1]};
					default: result = {opA[7], opA[7:1]};
				endcase
				flagsOut.c = (op == ALU_ROL || op == ALU_ROLC) ? opA[7] : opA[0];
				flagsOut.v = result[7] ^ opA[7];
			end
			ALU_SCF:
			begin
				flagsOut.c = 1'b1;
				setZs = 1'b0;
			end
			ALU_RCF:
			begin
				flagsOut.c = 1'b0;
				setZs = 1'b0;
			end
			ALU_CCF:
			begin
				flagsOut.c = ~flagsIn.c;
				setZs = 1'b0;
			end
			default: setZs = 1'b0;
		endcase
		if (setZs)
		begin
			flagsOut.z = (result == 8'h00);
			flagsOut.s = result[7];
		end
		// user bits pass
		flagsOut.userBitOne = flagsIn.userBitOne;
		flagsOut.userBitTwo = flagsIn.userBitTwo;
	end

	// =============================================
	// branch condition: low three bits pick, top bit inverts
	always_comb
	begin
		case (condSel[2:0])
			3'h0: base = 1'b0;
			3'h1: base = flagsIn.s ^ flagsIn.v;
			3'h2: base = flagsIn.z | (flagsIn.s ^ flagsIn.v);
			3'h3: base = flagsIn.c | flagsIn.z;
			3'h4: base = flagsIn.v;
			3'h5: base = flagsIn.s;
			3'h6: base = flagsIn.z;
			default: base = flagsIn.c;
		endcase
		condTrue = base ^ condSel[3];
	end

endmodule

`default_nettype wire

// *** cfsa_map.svh ***
/*
 offsets, field positions and reset values of the slice.
 assumes inclusion by bare name.
*/
`ifndef CFSA_MAP_SVH
`define CFSA_MAP_SVH

// =============================================
// register offsets
`define CFSA_OFS_PCFG 8'hF8
`define CFSA_OFS_FLAGS 8'hFC
`define CFSA_OFS_GROUP 8'hFD
`define CFSA_OFS_SP_HI 8'hFE
`define CFSA_OFS_SP_LO 8'hFF

// =============================================
// field positions
`define CFSA_PCFG_STK_BIT 2
`define CFSA_WRK_PREFIX 4'hE
`define CFSA_GROUP_RD_MASK 8'hF0

// =============================================
// reset values
`define CFSA_RST_FLAGS 8'h00
`define CFSA_RST_GROUP 8'h00
`define CFSA_RST_SP 8'h00
`define CFSA_RST_PCFG 8'h00

`endif

// *** cfsa_pkg.sv ***
/*
 types of the slice.
 assumes nothing.
*/
package cfsa_pkg;

	// =============================================
	// flag layout, bit 7 first
	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
		logic d;
		logic h;
		logic userBitTwo;
		logic userBitOne;
	} cfsa_flags_t;

	typedef enum logic [4:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_CP,
		ALU_AND, ALU_OR, ALU_XOR, ALU_TM, ALU_COM,
		ALU_INC, ALU_DEC,
		ALU_ROL, ALU_ROLC, ALU_ROR, ALU_RORC, ALU_SRA,
		ALU_SCF, ALU_RCF, ALU_CCF
	} cfsa_alu_op_t;

	typedef enum logic [2:0] {
		MODE_REG, MODE_POINTER, MODE_INDEX,
		MODE_ABSOLUTE, MODE_PCOFFSET, MODE_INLINE
	} cfsa_mode_t;

	typedef enum logic [1:0] {
		SPACE_REGFILE, SPACE_PROGRAM, SPACE_DATA
	} cfsa_space_t;

	typedef enum logic [2:0] {
		STK_PUSH, STK_POP, STK_CALL, STK_RET, STK_INT, STK_INTRET
	} cfsa_stk_op_t;

endpackage

// *** cfsa_stack_mem.sv ***
/*
 register file and data memory behind the stack port.
 assumes one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module cfsa_stack_mem
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// stack memory access
	input wire logic [15:0] memAddr,
	input wire logic memInternal,
	input wire logic memWr,
	input wire logic memRd,
	input wire logic [7:0] memWrData,
	output logic [7:0] memRdData
);
	logic [7:0] regFile [0:255];
	logic [7:0] extMem [0:65535];
	logic [7:0] lastRd_r;
	wire [7:0] cur = memInternal ? regFile[memAddr[7:0]] : extMem[memAddr];

	// idle: inverse of last read
	assign memRdData = memRd ? cur : ~lastRd_r;

	always_ff @(posedge clk_sys)
	begin
		if (memWr && memInternal)
			regFile[memAddr[7:0]] <= memWrData;
		if (memWr && !memInternal)
			extMem[memAddr] <= memWrData;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			lastRd_r <= 8'hA5;
		else if (memRd)
			lastRd_r <= cur;
	end
endmodule

`default_nettype wire

// *** cpu_flags_stack_addressing_tb_top.sv ***
/*
 bench: core, memory model, bound checker.
 assumes the package is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_flags_stack_addressing_tb_top
	import cfsa_pkg::*;
;
	// =============================================
	// signals
	logic clk_sys, reset, regWrEn, aluGo, agGo, agWide, stkGo, aluDone, condTrue;
	logic agAddrValid, agOperandValid, agDone, stkBusy, stkDone, pcLoad, memInternal, memWr, memRd;
	logic [7:0] regAddr, regWrData, regRdData, aluA, aluB, aluResult, opcodeByte, agRegField;
	logic [7:0] agRegVal, agIdxVal, agRegAddr, stkData, popData, memRdData, memWrData;
	logic [3:0] agIdxField, probe;
	logic [15:0] agPairVal, agInline, agNextPc, agAddr, agOperand, pcIn, pcOut, memAddr;
	cfsa_alu_op_t aluOp;
	cfsa_mode_t agMode;
	cfsa_space_t agSpace, agSpaceOut;
	cfsa_stk_op_t stkOp;
	cfsa_flags_t flagsView;
	logic [19:0] notes[$];
	logic [7:0] rstList [6] = '{8'hF8, 8'hFC, 8'hFD, 8'hFE, 8'hFF, 8'h10};
	int errCount, checks, seed;

	cfsa_core dut (.clk_sys, .reset, .regWrEn, .regAddr, .regWrData, .regRdData, .aluGo,
		.aluOp, .aluA, .aluB, .aluResult, .aluDone, .opcodeByte, .condTrue, .flagsView, .agGo,
		.agMode, .agSpace, .agWide, .agRegField, .agIdxField, .agRegVal, .agPairVal, .agIdxVal,
		.agInline, .agNextPc, .agRegAddr, .agAddr, .agOperand, .agSpaceOut, .agAddrValid,
		.agOperandValid, .agDone, .stkGo, .stkOp, .stkData, .pcIn, .stkBusy, .stkDone, .popData,
		.pcOut, .pcLoad, .memRdData, .memAddr, .memInternal, .memWr, .memRd, .memWrData);
	cfsa_stack_mem mem (.clk_sys, .reset, .memAddr, .memInternal, .memWr, .memRd, .memWrData,
		.memRdData);

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// =============================================
	// checking
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errCount++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic take(input logic [3:0] k, input logic [15:0] v, input string what);
		logic [19:0] n;
		n = (notes.size() > 0) ? notes.pop_front() : 20'hFFFFF;
		chk("noteKind", {12'h000, n[19:16]}, {12'h000, k});
		chk(what, v, n[15:0]);
	endtask

	task automatic stopTest;
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	function automatic logic condOf(input logic [3:0] sel, input logic [7:0] f);
		logic r;
		case (sel[2:0])
			3'd0: r = 1'b0;
			3'd1: r = f[5] ^ f[4];
			3'd2: r = f[6] | (f[5] ^ f[4]);
			3'd3: r = f[7] | f[6];
			3'd4: r = f[4];
			3'd5: r = f[5];
			3'd6: r = f[6];
			default: r = f[7];
		endcase
		return sel[3] ? !r : r;
	endfunction

	// compare results with the oldest note
	initial
	forever
	begin
		@(posedge clk_sys);
		#1;
		if (aluDone === 1'b1) take(4'h0, {8'h00, aluResult}, "aluResult");
		if (agDone === 1'b1 && notes.size() > 0 && notes[0][19:16] == 4'h2)
			take(4'h2, agOperand, "agOperand");
		else if (agDone === 1'b1)
			take(4'h1, agAddr, "agAddr");
		if (agDone === 1'b1) chk("agValid", {15'h0, agAddrValid ^ agOperandValid}, 16'h1);
		if (agDone === 1'b1 && notes.size() > 0 && notes[0][19:16] == 4'h7)
			take(4'h7, {8'h00, agRegAddr}, "agRegAddr");
		if (pcLoad === 1'b1) take(4'h3, pcOut, "pcOut");
		if (stkDone === 1'b1 && notes.size() > 0 && notes[0][19:16] == 4'h4)
			take(4'h4, {8'h00, popData}, "popData");
		if (probe == 4'h5) take(4'h5, {8'h00, regRdData}, "regRdData");
		if (probe == 4'h6) take(4'h6, {15'h0000, condTrue}, "condTrue");
	end

	// =============================================
	// drivers
	task automatic look(input logic [3:0] k, input logic [7:0] e);
		probe = k;
		notes.push_back({k, 8'h00, e});
		@(negedge clk_sys);
		probe = 4'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		regAddr = a;
		look(4'h5, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		{regWrEn, regAddr, regWrData} = {1'b1, a, d};
		@(negedge clk_sys);
		regWrEn = 1'b0;
	endtask

	task automatic alu(input cfsa_alu_op_t o, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] e);
		@(negedge clk_sys);
		aluOp = o;
		{aluGo, aluA, aluB} = {1'b1, a, b};
		notes.push_back({4'h0, 8'h00, e});
		@(negedge clk_sys);
		aluGo = 1'b0;
	endtask

	task automatic ag(input cfsa_mode_t m, input cfsa_space_t sp, input logic w,
		input logic [7:0] f, input logic [15:0] v, input logic [3:0] k, input logic [15:0] e,
		input logic [8:0] ra);
		@(negedge clk_sys);
		agMode = m;
		agSpace = sp;
		{agGo, agWide, agRegField} = {1'b1, w, f};
		{agPairVal, agInline, agRegVal, agIdxVal} = {v, v, v[7:0], v[7:0]};
		notes.push_back({k, e});
		if (ra[8])
			notes.push_back({4'h7, 8'h00, ra[7:0]});
	endtask

	task automatic stk(input cfsa_stk_op_t o, input logic [15:0] v);
		int n;
		stkOp = o;
		{stkGo, stkData, pcIn} = {1'b1, v[7:0], v};
		@(negedge clk_sys);
		stkGo = 1'b0;
		for (n = 0; n < 8 && stkDone !== 1'b1; n++)
			@(negedge clk_sys);
		if (n == 8)
		begin
			errCount++;
			stopTest();
		end
	endtask

	// =============================================
	// scenarios
	initial
	begin
		logic [7:0] a, b;
		logic [8:0] s;
		int i;
		{reset, seed, errCount, checks} = {1'b1, 32'h8447, 32'h0, 32'h0};
		{regWrEn, aluGo, agGo, agWide, stkGo, probe} = '0;
		{regAddr, regWrData, aluA, aluB, opcodeByte, agRegField, agRegVal, agIdxVal} = '0;
		{agPairVal, agInline, pcIn, stkData} = '0;
		{agIdxField, agNextPc} = {4'h7, 16'h0100};
		aluOp = ALU_ADD;
		agMode = MODE_REG;
		agSpace = SPACE_REGFILE;
		stkOp = STK_PUSH;
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		for (i = 0; i < 6; i++)
			rd(rstList[i], 8'h00);
		$display("reset values done");

		wr(8'hFC, 8'h03);
		alu(ALU_ADD, 8'h7F, 8'h01, 8'h80);
		rd(8'hFC, 8'h37);
		alu(ALU_SUB, 8'h00, 8'h01, 8'hFF);
		rd(8'hFC, 8'hAF);
		alu(ALU_AND, 8'hF0, 8'h0F, 8'h00);
		rd(8'hFC, 8'hCF);
		alu(ALU_ROL, 8'h80, 8'h00, 8'h01);
		rd(8'hFC, 8'h9F);
		alu(ALU_SRA, 8'h81, 8'h00, 8'hC0);
		rd(8'hFC, 8'hAF);
		for (i = 0; i < 6; i++)
		begin
			a = $random(seed);
			b = $random(seed);
			s = {1'b0, a} + {1'b0, b};
			alu(ALU_ADD, a, b, s[7:0]);
			rd(8'hFC, {s[8], s[7:0] == 8'h00, s[7], a[7] == b[7] && s[7] != a[7], 1'b0,
				{1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0F, 2'b11});
		end
		for (i = 0; i < 32; i++)
		begin
			if (i % 16 == 0)
				wr(8'hFC, (i < 16) ? 8'hA0 : 8'h50);
			@(negedge clk_sys);
			opcodeByte = {i[3:0], 4'h0};
			look(4'h6, {7'h00, condOf(i[3:0], (i < 16) ? 8'hA0 : 8'h50)});
		end
		$display("flag tests done");

		wr(8'hFD, 8'h3C);
		rd(8'hFD, 8'h30);
		ag(MODE_REG, SPACE_REGFILE, 1'b1, 8'hE4, 16'h1234, 4'h2, 16'h1234, 9'h000);
		ag(MODE_REG, SPACE_REGFILE, 1'b0, 8'hE5, 16'h005A, 4'h2, 16'h005A, 9'h135);
		ag(MODE_POINTER, SPACE_REGFILE, 1'b0, 8'h44, 16'h7744, 4'h1, 16'h0044, 9'h144);
		ag(MODE_POINTER, SPACE_DATA, 1'b0, 8'h62, 16'hBEEF, 4'h1, 16'hBEEF, 9'h000);
		ag(MODE_INDEX, SPACE_REGFILE, 1'b0, 8'h20, 16'h00F0, 4'h1, 16'h0010, 9'h137);
		ag(MODE_ABSOLUTE, SPACE_REGFILE, 1'b0, 8'h00, 16'h8000, 4'h1, 16'h8000, 9'h000);
		ag(MODE_PCOFFSET, SPACE_REGFILE, 1'b0, 8'h00, 16'h0080, 4'h1, 16'h0080, 9'h000);
		ag(MODE_PCOFFSET, SPACE_REGFILE, 1'b0, 8'h00, 16'h007F, 4'h1, 16'h017F, 9'h000);
		ag(MODE_INLINE, SPACE_REGFILE, 1'b0, 8'h00, 16'h12A5, 4'h2, 16'h00A5, 9'h000);
		@(negedge clk_sys);
		agGo = 1'b0;
		$display("address tests done");

		wr(8'hFE, 8'h10);
		wr(8'hFF, 8'h00);
		@(negedge clk_sys);
		notes.push_back({4'h3, 16'h1234});
		stk(STK_CALL, 16'h1234);
		stk(STK_RET, 16'h0000);
		chk("extMem", {8'h00, mem.extMem[16'h0FFF]}, 16'h0034);
		chk("extMem", {8'h00, mem.extMem[16'h0FFE]}, 16'h0012);
		stk(STK_PUSH, 16'h0077);
		notes.push_back({4'h4, 16'h0077});
		stk(STK_POP, 16'h0000);
		rd(8'hFF, 8'h00);
		wr(8'hFC, 8'h5A);
		@(negedge clk_sys);
		stk(STK_INT, 16'hABCD);
		chk("extMem", {8'h00, mem.extMem[16'h0FFD]}, 16'h005A);
		wr(8'hFC, 8'h00);
		@(negedge clk_sys);
		notes.push_back({4'h3, 16'hABCD});
		stk(STK_INTRET, 16'h0000);
		rd(8'hFC, 8'h5A);
		wr(8'hF8, 8'h04);
		wr(8'hFE, 8'h55);
		wr(8'hFF, 8'h00);
		@(negedge clk_sys);
		stk(STK_PUSH, 16'h009A);
		chk("regFile", {8'h00, mem.regFile[8'hFF]}, 16'h009A);
		rd(8'hFF, 8'hFF);
		rd(8'hFE, 8'h55);
		@(negedge clk_sys);
		notes.push_back({4'h4, 16'h009A});
		stk(STK_POP, 16'h0000);
		rd(8'hFF, 8'h00);
		$display("stack tests done");
		repeat (4) @(negedge clk_sys);
		stopTest();
	end
endmodule

bind cfsa_core cfsa_core_chk u_chk (.clk_sys, .reset, .aluGo, .aluOp, .aluA, .aluB, .aluResult,
	.flagsView, .agGo, .agMode, .agInline, .agNextPc, .agAddr, .agSpaceOut, .stkGo, .stkOp,
	.stkData, .pcIn, .stkBusy, .stkDone, .pcLoad, .memWr, .memRd, .memWrData);

`default_nettype wire
